// File: orla_cfg.svh
`ifndef ORLA_CFG_SVH
`define ORLA_CFG_SVH

// ----------------------------------------------------------------------------
// Opcode patterns
// ----------------------------------------------------------------------------
`define ORLA_OPC_OR_LIT     8'h09
`define ORLA_OPC_OR_REG     6'h04
`define ORLA_OPC_LDPTR      10'h3b8
`define ORLA_OPC_LDPTR2     4'h0

// ----------------------------------------------------------------------------
// Instruction field positions
// ----------------------------------------------------------------------------
`define ORLA_F_OP8          15:8
`define ORLA_F_OP6          15:10
`define ORLA_F_OP10         15:6
`define ORLA_F_OP4          15:12
`define ORLA_F_DEST         9
`define ORLA_F_ACC          8
`define ORLA_F_LIT8         7:0
`define ORLA_F_PSEL         5:4
`define ORLA_F_LITHI        3:0

// ----------------------------------------------------------------------------
// Addressing constants and reset values
// ----------------------------------------------------------------------------
`define ORLA_ILO_MAX        8'h5f
`define ORLA_ACC_LO_BANK    4'h0
`define ORLA_ACC_HI_BANK    4'hf
`define ORLA_IDX_PTR        2
`define ORLA_PTR_LAST       2'h2
`define ORLA_W_RST          8'h00
`define ORLA_PTR_RST        12'h000
`define ORLA_WORD_RST       16'h0000

`endif

// File: orla_pkg.sv
package orla_pkg;

    // Core phase states
    typedef enum logic [2:0] {
        ORLA_Q1,
        ORLA_Q2,
        ORLA_Q3,
        ORLA_Q4,
        ORLA_WAIT2,
        ORLA_Q2B,
        ORLA_Q3B,
        ORLA_Q4B
    } orla_state_t;

    // Decoded instruction kind
    typedef enum logic [1:0] {
        ORLA_K_OR_LIT,
        ORLA_K_OR_REG,
        ORLA_K_LDPTR,
        ORLA_K_NONE
    } orla_kind_t;

    // Data memory request
    typedef struct packed {
        logic        rd_en;
        logic        wr_en;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } orla_mem_req_t;

    // Status flags touched by the OR instructions
    typedef struct packed {
        logic n;
        logic z;
    } orla_flags_t;

    // Pointer registers as seen outside
    typedef struct packed {
        logic [11:0] p2;
        logic [11:0] p1;
        logic [11:0] p0;
    } orla_ptrs_t;

endpackage : orla_pkg

// File: orla_core.sv
`timescale 1ns/1ps
`include "orla_cfg.svh"

module orla_core
    import orla_pkg::*;
(
    // Clock and reset
    input  wire logic          clock,
    input  wire logic          reset_n,
    // Instruction fetch
    input  wire logic          instr_valid,
    input  wire logic [15:0]   instr_word,
    output logic               instr_ready,
    output logic               instr_done,
    output logic               instr_bad,
    // Configuration
    input  wire logic          ext_set_en,
    input  wire logic [7:0]    bank_select_register,
    // Data memory
    output orla_mem_req_t      mem_req,
    input  wire logic [7:0]    mem_rd_data,
    // Core state
    output logic [7:0]         w_reg,
    output orla_flags_t        flags,
    output orla_ptrs_t         indirect_address_pointer
);

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------

    // N and Z from a result byte
    function automatic orla_flags_t nz_of(input logic [7:0] v);
        orla_flags_t f;
        f.n = v[7];
        f.z = (v == `ORLA_W_RST);
        return f;
    endfunction : nz_of

    // Effective data address of an 8-bit operand
    function automatic logic [11:0] eff_addr(input logic [7:0] f, input logic a,
                                             input logic ext, input logic [7:0] bank,
                                             input logic [11:0] idx);
        logic [11:0] r;
        r = `ORLA_PTR_RST;
        if (a)
            r = {bank[3:0], f};
        else if (f <= `ORLA_ILO_MAX && ext)
            r = idx + {`ORLA_ACC_LO_BANK, f};
        else if (f <= `ORLA_ILO_MAX)
            r = {`ORLA_ACC_LO_BANK, f};
        else
            r = {`ORLA_ACC_HI_BANK, f};
        return r;
    endfunction : eff_addr

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    orla_state_t   state_q,  state_d;
    orla_kind_t    kind_q,   kind_d;
    logic [15:0]   ir_q,     ir_d;
    logic [7:0]    lo_q,     lo_d;
    logic [7:0]    res_q,    res_d;
    logic [7:0]    w_q,      w_d;
    orla_flags_t   flags_q,  flags_d;
    orla_mem_req_t req_q,    req_d;
    logic [11:0]   ptr_q [0:2];
    logic [11:0]   ptr_d [0:2];
    orla_kind_t    dec_kind;
    logic          take;

    // First-word decode
    always_comb begin
        if (instr_word[`ORLA_F_OP8] == `ORLA_OPC_OR_LIT)
            dec_kind = ORLA_K_OR_LIT;
        else if (instr_word[`ORLA_F_OP6] == `ORLA_OPC_OR_REG)
            dec_kind = ORLA_K_OR_REG;
        else if (instr_word[`ORLA_F_OP10] == `ORLA_OPC_LDPTR &&
                 instr_word[`ORLA_F_PSEL] <= `ORLA_PTR_LAST)
            dec_kind = ORLA_K_LDPTR;
        else
            dec_kind = ORLA_K_NONE;
    end

    assign take = instr_valid && instr_ready;

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        state_d     = state_q;
        kind_d      = kind_q;
        ir_d        = ir_q;
        lo_d        = lo_q;
        res_d       = res_q;
        w_d         = w_q;
        flags_d     = flags_q;
        req_d       = req_q;
        req_d.rd_en = 1'b0;
        req_d.wr_en = 1'b0;
        ptr_d       = ptr_q;
        instr_ready = (state_q == ORLA_Q1) || (state_q == ORLA_WAIT2);
        instr_done  = 1'b0;
        instr_bad   = 1'b0;
        case (state_q)
            // Q1: decode and present the operand address
            ORLA_Q1: begin
                if (instr_valid) begin
                    ir_d   = instr_word;
                    kind_d = dec_kind;
                    if (dec_kind == ORLA_K_NONE) begin
                        instr_bad = 1'b1;
                    end else begin
                        state_d = ORLA_Q2;
                    end
                    if (dec_kind == ORLA_K_OR_REG) begin
                        req_d.rd_en = 1'b1;
                        req_d.addr  = eff_addr(instr_word[`ORLA_F_LIT8], instr_word[`ORLA_F_ACC],
                                               ext_set_en, bank_select_register,
                                               ptr_q[`ORLA_IDX_PTR]);
                    end
                end
            end
            // Q2: read register or literal
            ORLA_Q2: begin
                state_d = ORLA_Q3;
            end
            // Q3: process data
            ORLA_Q3: begin
                state_d = ORLA_Q4;
                if (kind_q == ORLA_K_OR_LIT)
                    res_d = w_q | ir_q[`ORLA_F_LIT8];
                else if (kind_q == ORLA_K_OR_REG) begin
                    res_d = w_q | mem_rd_data;
                    if (ir_q[`ORLA_F_DEST]) begin
                        req_d.wr_en = 1'b1;
                        req_d.wdata = w_q | mem_rd_data;
                    end
                end
            end
            // Q4: write destination
            ORLA_Q4: begin
                if (kind_q == ORLA_K_LDPTR) begin
                    ptr_d[ir_q[`ORLA_F_PSEL]][11:8] = ir_q[`ORLA_F_LITHI];
                    state_d = ORLA_WAIT2;
                end else begin
                    if (kind_q == ORLA_K_OR_LIT || !ir_q[`ORLA_F_DEST])
                        w_d = res_q;
                    flags_d    = nz_of(res_q);
                    instr_done = 1'b1;
                    state_d    = ORLA_Q1;
                end
            end
            // Second word of the pointer load
            ORLA_WAIT2: begin
                if (instr_valid) begin
                    if (instr_word[`ORLA_F_OP4] == `ORLA_OPC_LDPTR2) begin
                        lo_d    = instr_word[`ORLA_F_LIT8];
                        state_d = ORLA_Q2B;
                    end else begin
                        instr_bad = 1'b1;
                        state_d   = ORLA_Q1;
                    end
                end
            end
            ORLA_Q2B: begin
                state_d = ORLA_Q3B;
            end
            ORLA_Q3B: begin
                state_d = ORLA_Q4B;
            end
            // Low byte lands, flags untouched
            ORLA_Q4B: begin
                ptr_d[ir_q[`ORLA_F_PSEL]][7:0] = lo_q;
                instr_done = 1'b1;
                state_d    = ORLA_Q1;
            end
            default: begin
                state_d = ORLA_Q1;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_q       <= ORLA_Q1;
            kind_q        <= ORLA_K_NONE;
            ir_q          <= `ORLA_WORD_RST;
            lo_q          <= `ORLA_W_RST;
            res_q         <= `ORLA_W_RST;
            w_q           <= `ORLA_W_RST;
            flags_q       <= '0;
            req_q         <= '0;
            for (int i = 0; i <= `ORLA_PTR_LAST; i++) begin
                ptr_q[i] <= `ORLA_PTR_RST;
            end
        end else begin
            state_q       <= state_d;
            kind_q        <= kind_d;
            ir_q          <= ir_d;
            lo_q          <= lo_d;
            res_q         <= res_d;
            w_q           <= w_d;
            flags_q       <= flags_d;
            req_q         <= req_d;
            ptr_q         <= ptr_d;
        end
    end

    // Outputs
    assign mem_req                     = req_q;
    assign w_reg                       = w_q;
    assign flags                       = flags_q;
    assign indirect_address_pointer.p0 = ptr_q[0];
    assign indirect_address_pointer.p1 = ptr_q[1];
    assign indirect_address_pointer.p2 = ptr_q[2];

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    logic acc_lit;
    logic acc_reg;
    logic acc_ptr;
    assign acc_lit = take && state_q == ORLA_Q1 && dec_kind == ORLA_K_OR_LIT;
    assign acc_reg = take && state_q == ORLA_Q1 && dec_kind == ORLA_K_OR_REG;
    assign acc_ptr = take && state_q == ORLA_Q1 && dec_kind == ORLA_K_LDPTR;

    property p_or_lit;
        @(posedge clock) disable iff (!reset_n)
        acc_lit |-> ##4 (w_q == ($past(w_q, 4) | $past(instr_word[7:0], 4)));
    endproperty
    a_or_lit: assert property (p_or_lit) else $error("OR literal result wrong");

    property p_or_flags;
        @(posedge clock) disable iff (!reset_n)
        acc_lit |-> ##4 (flags_q.z == (w_q == 8'h00) && flags_q.n == w_q[7]);
    endproperty
    a_or_flags: assert property (p_or_flags) else $error("N or Z flag wrong");

    property p_reg_read;
        @(posedge clock) disable iff (!reset_n)
        acc_reg |=> mem_req.rd_en &&
            (mem_req.addr[7:0] == $past(instr_word[7:0]) ||
             $past(!instr_word[8] && ext_set_en && instr_word[7:0] <= 8'h5f));
    endproperty
    a_reg_read: assert property (p_reg_read) else $error("Register read missing");

    property p_dest_w;
        @(posedge clock) disable iff (!reset_n)
        acc_reg && !instr_word[9] |-> ##3 !mem_req.wr_en ##1 w_q == $past(res_q);
    endproperty
    a_dest_w: assert property (p_dest_w) else $error("d=0 did not write W");

    property p_dest_f;
        @(posedge clock) disable iff (!reset_n)
        acc_reg && instr_word[9] |-> ##3 mem_req.wr_en ##1 $stable(w_q);
    endproperty
    a_dest_f: assert property (p_dest_f) else $error("d=1 did not write f");

    property p_bank;
        @(posedge clock) disable iff (!reset_n)
        acc_reg && instr_word[8] |=> mem_req.addr[11:8] == $past(bank_select_register[3:0]);
    endproperty
    a_bank: assert property (p_bank) else $error("Bank select not used");

    property p_indexed;
        @(posedge clock) disable iff (!reset_n)
        acc_reg && !instr_word[8] && ext_set_en && instr_word[7:0] <= 8'h5f
            |=> mem_req.addr == $past(ptr_q[2]) + {4'h0, $past(instr_word[7:0])};
    endproperty
    a_indexed: assert property (p_indexed) else $error("Indexed offset address wrong");

    property p_ptr_flags;
        @(posedge clock) disable iff (!reset_n)
        acc_ptr |-> ##4 flags_q == $past(flags_q, 4);
    endproperty
    a_ptr_flags: assert property (p_ptr_flags) else $error("Pointer load changed flags");

    property p_ptr_hi;
        @(posedge clock) disable iff (!reset_n)
        acc_ptr && instr_word[5:4] == 2'h1 |-> ##4 ptr_q[1][11:8] == $past(instr_word[3:0], 4);
    endproperty
    a_ptr_hi: assert property (p_ptr_hi) else $error("Pointer high nibble wrong");

    property p_four_phase;
        @(posedge clock) disable iff (!reset_n)
        (acc_lit || acc_reg) |-> !instr_done [*3] ##1 instr_done;
    endproperty
    a_four_phase: assert property (p_four_phase) else $error("OR not four phases");

endmodule : orla_core

// File: orla_mem_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Data memory seen from the core
// ----------------------------------------------------------------------------
module orla_mem_model
    import orla_pkg::*;
(
    // Clock
    input  wire logic          clock,
    // Requests from the core
    input  wire orla_mem_req_t mem_req,
    output logic [7:0]         mem_rd_data
);
    logic [7:0] mem [0:4095];

    // Read answers one cycle later, writes land on the strobe edge
    initial mem_rd_data = 8'h00;
    always @(posedge clock) begin
        if (mem_req.wr_en) begin
            mem[mem_req.addr] <= mem_req.wdata;
        end
        // Outside a read the byte is inverted every cycle
        mem_rd_data <= mem_req.rd_en ? mem[mem_req.addr] : ~mem_rd_data;
    end
endmodule : orla_mem_model

// File: orla_core_bench.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Bench for the OR and pointer load core
// ----------------------------------------------------------------------------
module orla_core_bench
    import orla_pkg::*;
;
    logic          clock, reset_n, instr_valid, ext_set_en, got_done, got_bad;
    logic          instr_ready, instr_done, instr_bad;
    logic [15:0]   instr_word;
    logic [7:0]    bank_select_register, mem_rd_data, w_reg, lat;
    orla_mem_req_t mem_req;
    orla_flags_t   flags;
    orla_ptrs_t    indirect_address_pointer;
    int            error_cnt, tests_run, cyc;

    orla_core u_orla_core (.clock, .reset_n, .instr_valid, .instr_word, .instr_ready, .instr_done,
        .instr_bad, .ext_set_en, .bank_select_register, .mem_req, .mem_rd_data, .w_reg, .flags,
        .indirect_address_pointer);
    orla_mem_model u_orla_mem_model (.clock, .mem_req, .mem_rd_data);

    // Clock of 50 ns period
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // Cut a hang short
    initial cyc = 0;
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            error_cnt++;
            close_out;
        end
    end

    // Compare one value
    task chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        tests_run++;
        if (e !== g) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Offer one word, wait until done, refused or ready again
    task send(input logic [15:0] w);
        int n;
        @(posedge clock);
        instr_valid <= 1'b1;
        instr_word  <= w;
        n = 0;
        do @(negedge clock); while (!instr_ready && ++n < 8);
        got_bad  = instr_bad;
        got_done = 1'b0;
        @(posedge clock);
        instr_valid <= 1'b0;
        for (n = 1; n < 9 && !got_bad; n++) begin
            @(negedge clock);
            got_done = instr_done;
            if (instr_done || instr_ready) break;
        end
        lat = 8'(n);
        if (got_done) chk("cycles to done", 12'h003, {4'h0, lat});
        if (!got_bad) @(posedge clock);
        @(negedge clock);
    endtask : send

    // Report and end the run
    task close_out;
        $display("checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    // Main sequence
    initial begin
        reset_n = 1'b0;
        instr_valid = 1'b0;
        instr_word = 16'h0000;
        ext_set_en = 1'b0;
        bank_select_register = 8'h03;
        error_cnt = 0;
        tests_run = 0;
        u_orla_mem_model.mem[12'h312] = 8'h13;
        u_orla_mem_model.mem[12'hf80] = 8'h40;
        u_orla_mem_model.mem[12'h05f] = 8'h00;
        u_orla_mem_model.mem[12'h330] = 8'h08;
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        // Literal OR: zero, plain, negative
        send(16'h0900);
        chk("flags", 12'h001, {10'h0, flags});
        send(16'h0935);
        chk("w", 12'h035, {4'h0, w_reg});
        send(16'h0980);
        chk("w", 12'h0b5, {4'h0, w_reg});
        chk("flags", 12'h002, {10'h0, flags});
        // Register OR through bank select into W, then back into access bank
        send(16'h1112);
        chk("w", 12'h0b7, {4'h0, w_reg});
        chk("mem 312", 12'h013, {4'h0, u_orla_mem_model.mem[12'h312]});
        send(16'h1280);
        chk("mem f80", 12'h0f7, {4'h0, u_orla_mem_model.mem[12'hf80]});
        chk("w", 12'h0b7, {4'h0, w_reg});
        send(16'h125f);
        chk("mem 05f", 12'h0b7, {4'h0, u_orla_mem_model.mem[12'h05f]});
        // Pointer loads on every index
        for (int i = 0; i < 3; i++) begin
            send({10'h3b8, 2'(i), 4'(i + 1)});
            chk("pointer high", {4'(i + 1), 8'h00}, indirect_address_pointer[12*i +: 12]);
            send(16'h0020);
            chk("pointer", {4'(i + 1), 8'h20}, indirect_address_pointer[12*i +: 12]);
        end
        chk("flags", 12'h002, {10'h0, flags});
        // Indexed offset from the third pointer
        @(posedge clock);
        ext_set_en <= 1'b1;
        send(16'h1010);
        chk("w", 12'h0bf, {4'h0, w_reg});
        // Refused words leave W alone; a pointer load refused at its second word keeps its new high nibble
        send(16'hee3a);
        chk("bad", 12'h001, {11'h0, got_bad});
        send(16'hffff);
        chk("bad", 12'h001, {11'h0, got_bad});
        send(16'hee05);
        send(16'h1000);
        chk("bad", 12'h001, {11'h0, got_bad});
        chk("pointer", 12'h520, indirect_address_pointer.p0);
        chk("w", 12'h0bf, {4'h0, w_reg});
        close_out;
    end
endmodule : orla_core_bench
